/* File: hdl/mbd_pkg.sv */
package mbd_pkg;
   localparam int RQ_W = 12;
   localparam int RQ_WORDS = 2;
   localparam int PKT_WIN = 16;
   localparam int WIN_PER_CYC = 8;
   localparam int DQ_W = 16;
   localparam int PKT_W = DQ_W * PKT_WIN;
   localparam int BANKS = 8;
   localparam int BANK_W = 3;
   localparam int MAX_OPEN = 4;
   localparam int ADDR_W = 8;
   localparam int CMD_W = 3;
   localparam int CMD_LSB = 21;
   localparam int BANK_LSB = 18;
   localparam int ADDR_LSB = 10;
   localparam int SYNC_STAGES = 3;
   localparam int SYS_CLK_NS = 10;
   localparam int LINK_DIV = 16;
   localparam int CLOCK_PERIOD_NS = SYS_CLK_NS * LINK_DIV;
   localparam int BIT_WINDOW_NS = CLOCK_PERIOD_NS / WIN_PER_CYC;
   localparam int BIT_CYC = BIT_WINDOW_NS / SYS_CLK_NS;
   localparam int PH_W = 5;
   localparam logic [PH_W-1:0] RQ_SAMPLE0 = PH_W'(LINK_DIV / (2 * RQ_WORDS));
   localparam logic [PH_W-1:0] RQ_SAMPLE1 = PH_W'(LINK_DIV / RQ_WORDS + LINK_DIV / (2 * RQ_WORDS));
   localparam int RX_SKEW = 8;
   // Request spacing and data offsets, in link clock cycles
   localparam int WRITE_DATA_DELAY = 3;
   localparam int COLUMN_ACCESS_LATENCY = 6;
   localparam int ACTIVATE_TO_WRITE_GAP = 1;
   localparam int ACTIVATE_TO_READ_GAP = 5;
   localparam int COLUMN_TO_COLUMN_GAP = 2;
   localparam int WRITE_TO_CLOSE_GAP = 10;
   localparam int READ_TO_CLOSE_GAP = 3;
   localparam int GAP_W = 5;
   typedef enum logic [CMD_W-1:0] {MBD_NOP, MBD_ACT, MBD_WR, MBD_RD, MBD_PRE} mbd_cmd_t;
endpackage

/* File: hdl/mbd_link_if.sv */
`timescale 1ns/10ps
interface mbd_link_if
   import mbd_pkg::*;
();
   logic master_clock_pos;
   logic master_clock_neg;
   logic [RQ_W-1:0] request_bus;
   logic [DQ_W-1:0] ctl_dq_out;
   logic ctl_dq_oe;
   logic [DQ_W-1:0] dev_dq_out;
   logic dev_dq_oe;
   logic [DQ_W-1:0] data_bus_pos;
   logic [DQ_W-1:0] data_bus_neg;
   // Undriven bus settles to zero; both drivers at once is a protocol fault
   assign data_bus_pos = ctl_dq_oe ? ctl_dq_out : (dev_dq_oe ? dev_dq_out : '0);
   assign data_bus_neg = ~data_bus_pos;
   modport ctl (output master_clock_pos, master_clock_neg, request_bus, ctl_dq_out, ctl_dq_oe,
                input data_bus_pos, data_bus_neg);
   modport dev (input master_clock_pos, master_clock_neg, request_bus, data_bus_pos, data_bus_neg,
                output dev_dq_out, dev_dq_oe);
endinterface

/* File: hdl/mbd_fifo.sv */
`timescale 1ns/10ps
module mbd_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
      $error("mbd_fifo: DEPTH must be a power of two of at least 2");
   end
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
   logic [AW:0] cnt, next_cnt;
   logic next_ready, next_ovalid, push, pop;
   always_comb begin
      push = in_valid_i & in_ready_o;
      pop = (cnt != '0) & (~out_valid_o | out_ready_i);
      next_wptr = push ? wptr + 1'b1 : wptr;
      next_rptr = pop ? rptr + 1'b1 : rptr;
      next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // Ready follows the true fill level, so the source stalls when full
      next_ready = next_cnt < (AW+1)'(DEPTH);
      next_ovalid = pop | (out_valid_o & ~out_ready_i);
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wptr <= '0;
         rptr <= '0;
         cnt <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         cnt <= next_cnt;
         in_ready_o <= next_ready;
         out_valid_o <= next_ovalid;
         if (pop) begin
            out_data_o <= mem[rptr];
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wptr] <= in_data_i;
      end
   end
endmodule

/* File: hdl/mbd_device.sv */
`timescale 1ns/10ps
module mbd_device
   import mbd_pkg::*;
#(
   parameter int ROWS = 4,
   parameter int COLS = 4
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   mbd_link_if.dev link,
   output logic [BANKS-1:0] OPEN_BANKS_O,
   output logic PROTO_ERR_O
);
   localparam int RA_W = (ROWS > 1) ? $clog2(ROWS) : 1;
   localparam int CA_W = (COLS > 1) ? $clog2(COLS) : 1;
   localparam int CWD = WRITE_DATA_DELAY;
   localparam int CAC = COLUMN_ACCESS_LATENCY;
   localparam int L = SYNC_STAGES - 1;
   if ((1 << RA_W) != ROWS || (1 << CA_W) != COLS || RA_W > ADDR_W || CA_W > ADDR_W
       || CWD < 1 || CAC < 1 || LINK_DIV != 2 * WIN_PER_CYC) begin : g_bad
      $error("mbd_device: unsupported geometry or timing");
   end

   logic [COLS-1:0][PKT_W-1:0] core [BANKS*ROWS];
   logic [COLS-1:0][PKT_W-1:0] sense [BANKS];

   logic [SYNC_STAGES-1:0] clk_s;
   logic [SYNC_STAGES-1:0][RQ_W-1:0] rq_s;
   logic [SYNC_STAGES-1:0][DQ_W-1:0] dq_s;

   logic clk_lvl, next_clk_lvl;
   logic [PH_W-1:0] ph, next_ph, ph_eff;
   logic [RQ_W-1:0] rq_hi, next_rq_hi;
   logic [CWD-1:0] wv, next_wv;
   logic [CWD-1:0][BANK_W-1:0] wb, next_wb;
   logic [CWD-1:0][CA_W-1:0] wc, next_wc;
   logic [CAC-1:0] rv, next_rv;
   logic [CAC-1:0][PKT_W-1:0] rdat, next_rdat;
   logic rx_on, next_rx_on, rx_off, next_rx_off, rx_wr, next_rx_wr;
   logic [BANK_W-1:0] rx_bank, next_rx_bank;
   logic [CA_W-1:0] rx_col, next_rx_col;
   logic [PKT_W-1:0] rx_buf, next_rx_buf;
   logic tx_on, next_tx_on, tx_off, next_tx_off;
   logic [PKT_W-1:0] tx_buf, next_tx_buf;
   logic [DQ_W-1:0] dq_out, next_dq_out;
   logic dq_oe, next_dq_oe;
   logic [BANKS-1:0] open, next_open;
   logic [BANKS-1:0][RA_W-1:0] row, next_row;
   logic err, next_err;

   logic rise, dec, start_rx, start_tx, cur_off;
   logic [2*RQ_W-1:0] req;
   mbd_cmd_t cmd;
   logic [BANK_W-1:0] dbank;
   logic [RA_W-1:0] drow;
   logic [CA_W-1:0] dcol;
   logic [3:0] idx;

   // The first stage of each synchroniser feeds only the second
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         clk_s <= '0;
         rq_s <= '0;
         dq_s <= '0;
      end else begin
         clk_s <= {clk_s[L-1:0], link.master_clock_pos};
         rq_s <= {rq_s[L-1:0], link.request_bus};
         dq_s <= {dq_s[L-1:0], link.data_bus_pos};
      end
   end

   always_comb begin
      next_clk_lvl = (clk_s[L-1] == clk_s[L]) ? clk_s[L] : clk_lvl;
      rise = clk_s[L-1] & clk_s[L] & ~clk_lvl;
      ph_eff = rise ? '0 : ph;
      next_ph = (ph_eff == '1) ? ph_eff : ph_eff + 1'b1;
      // First request word is held until the second arrives
      next_rq_hi = (ph_eff == RQ_SAMPLE0) ? rq_s[L] : rq_hi;
      req = {rq_hi, rq_s[L]};
      dec = (ph_eff == RQ_SAMPLE1);
      cmd = mbd_cmd_t'(req[CMD_LSB +: CMD_W]);
      dbank = req[BANK_LSB +: BANK_W];
      drow = req[ADDR_LSB +: RA_W];
      dcol = req[ADDR_LSB +: CA_W];

      next_open = open;
      next_row = row;
      next_err = err;
      next_wv = wv;
      next_wb = wb;
      next_wc = wc;
      next_rv = rv;
      next_rdat = rdat;
      start_rx = rise & wv[0];
      start_tx = rise & rv[0];
      // Offset pipelines advance once per link clock
      if (rise) begin
         next_wv = wv >> 1;
         next_wb = wb >> BANK_W;
         next_wc = wc >> CA_W;
         next_rv = rv >> 1;
         next_rdat = rdat >> PKT_W;
      end
      if (dec) begin
         case (cmd)
            MBD_ACT: begin
               next_err = err | open[dbank];
               next_open[dbank] = 1'b1;
               next_row[dbank] = drow;
            end
            MBD_PRE: begin
               next_err = err | ~open[dbank];
               next_open[dbank] = 1'b0;
            end
            MBD_WR: begin
               next_err = err | ~open[dbank];
               next_wv[CWD-1] = 1'b1;
               next_wb[CWD-1] = dbank;
               next_wc[CWD-1] = dcol;
            end
            MBD_RD: begin
               next_err = err | ~open[dbank];
               next_rv[CAC-1] = 1'b1;
               next_rdat[CAC-1] = sense[dbank][dcol];
            end
            default: begin
            end
         endcase
      end

      // Write capture: window k sampled mid-window at phase 2k+1
      next_rx_on = rx_on;
      next_rx_off = rx_off;
      next_rx_bank = rx_bank;
      next_rx_col = rx_col;
      next_rx_buf = rx_buf;
      next_rx_wr = 1'b0;
      if (start_rx) begin
         next_rx_on = 1'b1;
         next_rx_off = 1'b0;
         next_rx_bank = wb[0];
         next_rx_col = wc[0];
      end else if (rise && rx_on) begin
         next_rx_off = 1'b1;
      end
      idx = {rx_off, ph_eff[3:1]};
      if (rx_on && ph_eff[0] && !ph_eff[4]) begin
         next_rx_buf[idx*DQ_W +: DQ_W] = dq_s[L];
         if (idx == 4'hf) begin
            next_rx_on = 1'b0;
            next_rx_wr = 1'b1;
         end
      end

      // Read launch: window k driven for two system cycles
      next_tx_on = tx_on;
      next_tx_buf = tx_buf;
      cur_off = start_tx ? 1'b0 : (rise ? 1'b1 : tx_off);
      next_tx_off = cur_off;
      if (start_tx) begin
         next_tx_on = 1'b1;
         next_tx_buf = rdat[0];
      end
      next_dq_out = '0;
      next_dq_oe = 1'b0;
      if (next_tx_on && !ph_eff[4]) begin
         next_dq_out = next_tx_buf[{cur_off, ph_eff[3:1]}*DQ_W +: DQ_W];
         next_dq_oe = 1'b1;
         if (cur_off && ph_eff[3:0] == 4'hf) begin
            next_tx_on = 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         clk_lvl <= 1'b0;
         ph <= '1;
         rq_hi <= '0;
         wv <= '0;
         wb <= '0;
         wc <= '0;
         rv <= '0;
         rdat <= '0;
         rx_on <= 1'b0;
         rx_off <= 1'b0;
         rx_wr <= 1'b0;
         rx_bank <= '0;
         rx_col <= '0;
         rx_buf <= '0;
         tx_on <= 1'b0;
         tx_off <= 1'b0;
         tx_buf <= '0;
         dq_out <= '0;
         dq_oe <= 1'b0;
         open <= '0;
         row <= '0;
         err <= 1'b0;
      end else begin
         clk_lvl <= next_clk_lvl;
         ph <= next_ph;
         rq_hi <= next_rq_hi;
         wv <= next_wv;
         wb <= next_wb;
         wc <= next_wc;
         rv <= next_rv;
         rdat <= next_rdat;
         rx_on <= next_rx_on;
         rx_off <= next_rx_off;
         rx_wr <= next_rx_wr;
         rx_bank <= next_rx_bank;
         rx_col <= next_rx_col;
         rx_buf <= next_rx_buf;
         tx_on <= next_tx_on;
         tx_off <= next_tx_off;
         tx_buf <= next_tx_buf;
         dq_out <= next_dq_out;
         dq_oe <= next_dq_oe;
         open <= next_open;
         row <= next_row;
         err <= next_err;
      end
   end

   // Eight independent banks, each with its own sense-amp row
   always_ff @(posedge CLK_I) begin
      if (dec && cmd == MBD_ACT) begin
         sense[dbank] <= core[{dbank, drow}];
      end
      if (dec && cmd == MBD_PRE) begin
         core[{dbank, row[dbank]}] <= sense[dbank];
      end
      if (rx_wr) begin
         sense[rx_bank][rx_col] <= rx_buf;
      end
   end

   assign link.dev_dq_out = dq_out;
   assign link.dev_dq_oe = dq_oe;
   assign OPEN_BANKS_O = open;
   assign PROTO_ERR_O = err;
endmodule

/* File: hdl/mbd_controller.sv */
`timescale 1ns/10ps
module mbd_controller
   import mbd_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   mbd_link_if.ctl link,
   input wire logic CMD_VALID_I,
   output logic CMD_READY_O,
   input wire logic [CMD_W-1:0] CMD_OP_I,
   input wire logic [BANK_W-1:0] CMD_BANK_I,
   input wire logic [ADDR_W-1:0] CMD_ADDR_I,
   input wire logic [PKT_W-1:0] CMD_WDATA_I,
   output logic RD_VALID_O,
   input wire logic RD_READY_I,
   output logic [PKT_W-1:0] RD_DATA_O
);
   localparam int CWD = WRITE_DATA_DELAY;
   localparam int CAC = COLUMN_ACCESS_LATENCY;
   localparam int L = SYNC_STAGES - 1;
   localparam logic [GAP_W-1:0] G_AW = GAP_W'(ACTIVATE_TO_WRITE_GAP - 1);
   localparam logic [GAP_W-1:0] G_AR = GAP_W'(ACTIVATE_TO_READ_GAP - 1);
   localparam logic [GAP_W-1:0] G_CC = GAP_W'(COLUMN_TO_COLUMN_GAP - 1);
   localparam logic [GAP_W-1:0] G_WP = GAP_W'(WRITE_TO_CLOSE_GAP - 1);
   localparam logic [GAP_W-1:0] G_RP = GAP_W'(READ_TO_CLOSE_GAP - 1);
   localparam logic [3:0] LAST_PH = 4'(LINK_DIV - 1);
   if (LINK_DIV != 16 || CWD < 1 || CAC < 1 || WRITE_TO_CLOSE_GAP > 31) begin : g_bad
      $error("mbd_controller: unsupported timing");
   end

   logic [SYNC_STAGES-1:0][DQ_W-1:0] dq_s;
   logic [3:0] ph;
   logic mclk, ready, next_ready, legal, acc, edge0, cap_s, push, next_push, rd_out, next_rd_out;
   logic [RQ_W-1:0] rq, next_rq, rq_lo, next_rq_lo;
   logic [CWD-1:0] wv, next_wv;
   logic [CWD-1:0][PKT_W-1:0] wd, next_wd;
   logic [CAC-1:0] rv, next_rv;
   logic [DQ_W-1:0] dq_out, next_dq_out;
   logic oe, next_oe;
   logic [4:0] tcnt, next_tcnt, ccnt, next_ccnt, tcur, ccur;
   logic [PKT_W-1:0] tbuf, next_tbuf, cbuf, next_cbuf;
   logic [RX_SKEW:0] dly, next_dly;
   logic cap_on, next_cap_on;
   logic [BANKS-1:0] open, next_open, last_wr, next_last_wr;
   logic [BANKS-1:0][GAP_W-1:0] s_act, next_s_act, s_col, next_s_col;
   logic [GAP_W-1:0] s_any, next_s_any;
   logic fifo_ready;
   mbd_cmd_t op;

   always_comb begin
      op = mbd_cmd_t'(CMD_OP_I);
      // Spacing, bank state and bus turnaround are enforced before issue
      case (op)
         MBD_ACT: legal = !open[CMD_BANK_I] && $countones(open) < MAX_OPEN;
         MBD_WR: legal = open[CMD_BANK_I] && s_act[CMD_BANK_I] >= G_AW && s_any >= G_CC && !rd_out;
         MBD_RD: legal = open[CMD_BANK_I] && s_act[CMD_BANK_I] >= G_AR && s_any >= G_CC && !rd_out
                         && wv == '0 && !oe && fifo_ready;
         MBD_PRE: legal = open[CMD_BANK_I] && s_col[CMD_BANK_I] >= (last_wr[CMD_BANK_I] ? G_WP : G_RP);
         default: legal = 1'b1;
      endcase
      // Ready is raised only in the last phase, so every request starts a link cycle
      next_ready = (ph == LAST_PH - 4'h1) && CMD_VALID_I && legal;
      edge0 = (ph == LAST_PH);
      acc = ready & CMD_VALID_I;
      next_rq = rq;
      next_rq_lo = rq_lo;
      next_wv = wv;
      next_wd = wd;
      next_rv = rv;
      next_open = open;
      next_last_wr = last_wr;
      next_s_act = s_act;
      next_s_col = s_col;
      next_s_any = s_any;
      next_rd_out = rd_out & ~push;
      if (ph == 4'(LINK_DIV / RQ_WORDS - 1)) begin
         next_rq = rq_lo;
      end
      if (edge0) begin
         next_rq = '0;
         next_wv = wv >> 1;
         next_wd = wd >> PKT_W;
         next_rv = rv >> 1;
         next_s_any = (s_any == '1) ? s_any : s_any + 1'b1;
         for (int b = 0; b < BANKS; b++) begin
            next_s_act[b] = (s_act[b] == '1) ? s_act[b] : s_act[b] + 1'b1;
            next_s_col[b] = (s_col[b] == '1) ? s_col[b] : s_col[b] + 1'b1;
         end
         if (acc) begin
            {next_rq, next_rq_lo} = {CMD_OP_I, CMD_BANK_I, CMD_ADDR_I, {ADDR_LSB{1'b0}}};
            case (op)
               MBD_ACT: begin
                  next_open[CMD_BANK_I] = 1'b1;
                  next_s_act[CMD_BANK_I] = '0;
                  next_s_col[CMD_BANK_I] = '0;
                  next_last_wr[CMD_BANK_I] = 1'b0;
               end
               MBD_PRE: next_open[CMD_BANK_I] = 1'b0;
               MBD_WR, MBD_RD: begin
                  next_s_col[CMD_BANK_I] = '0;
                  next_s_any = '0;
                  next_last_wr[CMD_BANK_I] = (op == MBD_WR);
                  if (op == MBD_WR) begin
                     next_wv[CWD-1] = 1'b1;
                     next_wd[CWD-1] = CMD_WDATA_I;
                  end else begin
                     next_rv[CAC-1] = 1'b1;
                     next_rd_out = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // Write data: window k for phases 2k and 2k+1 of the packet
      next_tbuf = tbuf;
      tcur = tcnt + 5'h01;
      next_oe = oe && (tcnt != 5'h1f);
      if (edge0 && wv[0]) begin
         next_tbuf = wd[0];
         tcur = '0;
         next_oe = 1'b1;
      end
      next_tcnt = tcur;
      next_dq_out = next_oe ? next_tbuf[tcur[4:1]*DQ_W +: DQ_W] : '0;
      // Read data sampled RX_SKEW cycles after the packet's first phase
      next_dly = {dly[RX_SKEW-1:0], edge0 & rv[0]};
      cap_s = dly[RX_SKEW];
      ccur = cap_s ? '0 : ccnt;
      next_cbuf = cbuf;
      next_cap_on = cap_s | cap_on;
      next_push = 1'b0;
      if (next_cap_on && !ccur[0]) begin
         next_cbuf[ccur[4:1]*DQ_W +: DQ_W] = dq_s[L];
         if (ccur == 5'h1e) begin
            next_cap_on = 1'b0;
            next_push = 1'b1;
         end
      end
      next_ccnt = ccur + 5'h01;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         dq_s <= '0;
         // Starting in the last phase gives the first link clock a full high phase
         ph <= '1;
         mclk <= 1'b0;
         ready <= 1'b0;
         rq <= '0;
         rq_lo <= '0;
         wv <= '0;
         wd <= '0;
         rv <= '0;
         dq_out <= '0;
         oe <= 1'b0;
         tcnt <= '0;
         tbuf <= '0;
         dly <= '0;
         cap_on <= 1'b0;
         ccnt <= '0;
         cbuf <= '0;
         push <= 1'b0;
         rd_out <= 1'b0;
         open <= '0;
         last_wr <= '0;
         s_act <= '1;
         s_col <= '1;
         s_any <= '1;
      end else begin
         dq_s <= {dq_s[L-1:0], link.data_bus_pos};
         ph <= ph + 4'h1;
         mclk <= (ph + 4'h1) < 4'(LINK_DIV / 2);
         ready <= next_ready;
         rq <= next_rq;
         rq_lo <= next_rq_lo;
         wv <= next_wv;
         wd <= next_wd;
         rv <= next_rv;
         dq_out <= next_dq_out;
         oe <= next_oe;
         tcnt <= next_tcnt;
         tbuf <= next_tbuf;
         dly <= next_dly;
         cap_on <= next_cap_on;
         ccnt <= next_ccnt;
         cbuf <= next_cbuf;
         push <= next_push;
         rd_out <= next_rd_out;
         open <= next_open;
         last_wr <= next_last_wr;
         s_act <= next_s_act;
         s_col <= next_s_col;
         s_any <= next_s_any;
      end
   end

   // Reads stay outstanding one at a time, so a free slot is known at issue
   mbd_fifo #(.W(PKT_W), .DEPTH(16)) u_rd_fifo (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i(cbuf),
      .out_valid_o(RD_VALID_O),
      .out_ready_i(RD_READY_I),
      .out_data_o(RD_DATA_O)
   );

   assign CMD_READY_O = ready;
   assign link.master_clock_pos = mclk;
   assign link.master_clock_neg = ~mclk;
   assign link.request_bus = rq;
   assign link.ctl_dq_out = dq_out;
   assign link.ctl_dq_oe = oe;
endmodule

/* File: test/mbd_link_props.sv */
`timescale 1ns/10ps
module mbd_link_props
   import mbd_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic master_clock_pos,
   input wire logic master_clock_neg,
   input wire logic [RQ_W-1:0] request_bus,
   input wire logic [DQ_W-1:0] ctl_dq_out,
   input wire logic ctl_dq_oe,
   input wire logic dev_dq_oe,
   input wire logic [DQ_W-1:0] data_bus_pos,
   input wire logic [DQ_W-1:0] data_bus_neg
);
   localparam int RD_LO = 96;
   localparam int RD_HI = 104;
   logic [4:0] wcnt;
   logic [4:0] rcnt;
   logic [4:0] next_wcnt;
   logic [4:0] next_rcnt;
   // Counts wrap at one packet so back-to-back packets restart at zero
   always_comb begin
      next_wcnt = ctl_dq_oe ? wcnt + 5'h1 : 5'h0;
      next_rcnt = dev_dq_oe ? rcnt + 5'h1 : 5'h0;
   end
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wcnt <= 5'h0;
         rcnt <= 5'h0;
      end else begin
         wcnt <= next_wcnt;
         rcnt <= next_rcnt;
      end
   end
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   sequence s_req(logic [CMD_W-1:0] op);
      $rose(master_clock_pos) && request_bus[RQ_W-1 -: CMD_W] == op;
   endsequence
   sequence s_link_cycle;
      master_clock_pos [*8] ##1 !master_clock_pos [*8] ##1 master_clock_pos;
   endsequence
   a_clk_compl: assert property (master_clock_neg == ~master_clock_pos) else $error("clock pair");
   a_data_compl: assert property (data_bus_neg == ~data_bus_pos) else $error("data pair");
   a_clk_period: assert property ($rose(master_clock_pos) |-> s_link_cycle) else $error("link period");
   a_rq_hold: assert property ($changed(request_bus) |=> $stable(request_bus) [*7]) else $error("rq word");
   a_rq_phase: assert property ($changed(request_bus) |-> $changed(master_clock_pos)) else $error("rq phase");
   a_no_clash: assert property (!(ctl_dq_oe && dev_dq_oe)) else $error("both drive data");
   a_wr_len: assert property ($fell(ctl_dq_oe) |-> wcnt == 5'h0) else $error("write length");
   a_rd_len: assert property ($fell(dev_dq_oe) |-> rcnt == 5'h0) else $error("read length");
   a_wr_win: assert property (ctl_dq_oe && wcnt[0] |-> $stable(ctl_dq_out)) else $error("write window");
   a_wr_offset: assert property (s_req(MBD_WR) |-> ##48 (ctl_dq_oe && wcnt == 5'h0))
      else $error("write data offset");
   a_rd_offset: assert property (s_req(MBD_RD) |-> ##[RD_LO:RD_HI] (dev_dq_oe && rcnt == 5'h0))
      else $error("read data offset");
endmodule

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb
   import mbd_pkg::*;
;
   logic CLK_I = 1'b0;
   logic RST_N_I = 1'b0;
   logic CMD_VALID_I = 1'b0;
   logic [CMD_W-1:0] CMD_OP_I = '0;
   logic [BANK_W-1:0] CMD_BANK_I = '0;
   logic [ADDR_W-1:0] CMD_ADDR_I = '0;
   logic [PKT_W-1:0] CMD_WDATA_I = '0;
   logic RD_READY_I = 1'b0;
   logic CMD_READY_O;
   logic RD_VALID_O;
   logic PROTO_ERR_O;
   logic [PKT_W-1:0] RD_DATA_O;
   logic [BANKS-1:0] OPEN_BANKS_O;
   int n_fail = 0;
   int cmp_count = 0;
   int seed = 32'h7565;
   int base;
   int n;
   int row [BANKS];
   logic [BANKS-1:0] open_m = '0;
   logic [PKT_W-1:0] mem [int];
   logic [PKT_W-1:0] exp_q [$];
   always #5 CLK_I = ~CLK_I;
   mbd_link_if mbd_link_if_i ();
   mbd_controller mbd_controller_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .link(mbd_link_if_i),
      .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O), .CMD_OP_I(CMD_OP_I), .CMD_BANK_I(CMD_BANK_I),
      .CMD_ADDR_I(CMD_ADDR_I), .CMD_WDATA_I(CMD_WDATA_I), .RD_VALID_O(RD_VALID_O), .RD_READY_I(RD_READY_I),
      .RD_DATA_O(RD_DATA_O));
   mbd_device mbd_device_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .link(mbd_link_if_i),
      .OPEN_BANKS_O(OPEN_BANKS_O), .PROTO_ERR_O(PROTO_ERR_O));
   mbd_link_props mbd_link_props_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
      .master_clock_pos(mbd_link_if_i.master_clock_pos), .master_clock_neg(mbd_link_if_i.master_clock_neg),
      .request_bus(mbd_link_if_i.request_bus), .ctl_dq_out(mbd_link_if_i.ctl_dq_out),
      .ctl_dq_oe(mbd_link_if_i.ctl_dq_oe), .dev_dq_oe(mbd_link_if_i.dev_dq_oe),
      .data_bus_pos(mbd_link_if_i.data_bus_pos), .data_bus_neg(mbd_link_if_i.data_bus_neg));
   task automatic chk(input logic [PKT_W-1:0] seen, input logic [PKT_W-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // A refused command must see no ready within the window, then is withdrawn
   task automatic cmd(input int op, input int b, input int a, input bit ok);
      int k;
      logic [PKT_W-1:0] d;
      for (int i = 0; i < 8; i++) begin
         d[32*i +: 32] = $random(seed);
      end
      k = b * 65536 + row[b] * 256 + a;
      @(posedge CLK_I);
      CMD_VALID_I <= 1'b1;
      CMD_OP_I <= CMD_W'(op);
      CMD_BANK_I <= BANK_W'(b);
      CMD_ADDR_I <= ADDR_W'(a);
      CMD_WDATA_I <= d;
      n = 0;
      do begin
         @(posedge CLK_I);
         n++;
      end while (CMD_READY_O !== 1'b1 && n < (ok ? 1000 : 300));
      CMD_VALID_I <= 1'b0;
      if (!ok) begin
         chk(CMD_READY_O, 1'b0);
      end else if (n >= 1000) begin
         n_fail++;
         summarize();
      end else begin
         case (op)
            1: begin
               open_m[b] = 1'b1;
               row[b] = a;
            end
            2: mem[k] = d;
            3: exp_q.push_back(mem[k]);
            default: open_m[b] = 1'b0;
         endcase
      end
   endtask
   task automatic chk_open();
      repeat (48) @(posedge CLK_I);
      chk(OPEN_BANKS_O, open_m);
   endtask
   always @(posedge CLK_I) begin
      RD_READY_I <= 1'($random(seed));
      if (RD_VALID_O === 1'b1 && RD_READY_I === 1'b1) begin
         chk(RD_DATA_O, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      end
   end
   initial begin
      repeat (3) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      repeat (40) @(posedge CLK_I);
      cmd(MBD_RD, 2, 0, 0);
      for (int r = 0; r < 3; r++) begin
         base = $random(seed) & 7;
         for (int i = 0; i < 4; i++) begin
            cmd(MBD_ACT, (base + i) % 8, $random(seed) & 3, 1);
         end
         cmd(MBD_ACT, (base + 4) % 8, 0, 0);
         chk_open();
         for (int i = 0; i < 8; i++) begin
            cmd(MBD_WR, (base + i / 2) % 8, i % 2 + r, 1);
         end
         for (int i = 7; i >= 0; i--) begin
            cmd(MBD_RD, (base + i / 2) % 8, i % 2 + r, 1);
         end
         for (int i = 0; i < 4; i++) begin
            cmd(MBD_PRE, (base + i) % 8, 0, 1);
         end
         chk_open();
      end
      n = 0;
      while (exp_q.size() > 0 && n < 3000) begin
         @(posedge CLK_I);
         n++;
      end
      chk(exp_q.size(), 0);
      chk(PROTO_ERR_O, 1'b0);
      summarize();
   end
endmodule
